// >>> design/sspp_defines.vh
// shared constants for the soft start / power good / polarity sequencer
`ifndef SSPP_DEFINES_VH
`define SSPP_DEFINES_VH

// bus geometry and timer counter width
`define SSPP_AW 8
`define SSPP_DW 32
`define SSPP_CW 27

// register indices; the byte address is four times the index
`define SSPP_IDX_PWRSS 8'h2C
`define SSPP_IDX_POL 8'h2D
// own registers, byte addresses
`define SSPP_ADDR_STAT 8'hC0
`define SSPP_ADDR_MASK 8'hC4
`define SSPP_ADDR_MON 8'hC8

// reset values
`define SSPP_PWRSS_RST 8'h00
`define SSPP_POL_RST 8'h00
`define SSPP_MASK_RST 6'h00

// power-on / soft start register fields
`define SSPP_SRC_HI 7
`define SSPP_SRC_LO 6
`define SSPP_SWON_BIT 5
`define SSPP_DLY_HI 4
`define SSPP_DLY_LO 3
`define SSPP_SSTOP_BIT 2
`define SSPP_SS_HI 1
`define SSPP_SS_LO 0

// polarity / power good register fields
`define SSPP_DEB_HI 7
`define SSPP_DEB_LO 4
`define SSPP_PG2ALL_BIT 3
`define SSPP_FLPOL_BIT 2
`define SSPP_GATEPOL_BIT 1
`define SSPP_PONPOL_BIT 0

// power-on source codes
`define SSPP_SRC_ALWAYS 2'h0
`define SSPP_SRC_PIN 2'h1
`define SSPP_SRC_SW 2'h2
`define SSPP_SRC_BOTH 2'h3

// interrupt events
`define SSPP_EV_N 6
`define SSPP_EV_PG1_RISE 0
`define SSPP_EV_PG1_FALL 1
`define SSPP_EV_FAULT_OFF 2
`define SSPP_EV_SS_DONE 3
`define SSPP_EV_STOP_DONE 4
`define SSPP_EV_PG2_FALL 5

// fault inputs that must be within limits for power good
`define SSPP_LIM_N 7

// times and clock rate
`define SSPP_CLK_HZ 40000000
`define SSPP_DLY_HALF_MS 500
`define SSPP_DLY_ONE_MS 1000
`define SSPP_DLY_TWO_MS 2000
`define SSPP_SS_360_US 360
`define SSPP_SS_10_MS 10
`define SSPP_SS_20_MS 20
`define SSPP_SS_40_MS 40
`define SSPP_DEB_320_MS 320
`define SSPP_DEB_200_MS 200
`define SSPP_DEB_600_MS 600

`endif

// >>> design/sspp_timer.v
// down-counting interval timer, reloadable
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defines.vh"
module sspp_timer (
  input wire clk,
  input wire arst_n,
  input wire load,
  input wire [`SSPP_CW-1:0] load_val,
  output wire expired
);
  reg [`SSPP_CW-1:0] cnt_q;
  reg [`SSPP_CW-1:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != {`SSPP_CW{1'b0}}) begin
      cnt_d = cnt_q - {{(`SSPP_CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {`SSPP_CW{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // a zero load expires on the very next cycle
  assign expired = (cnt_q == {`SSPP_CW{1'b0}});
endmodule // sspp_timer
`default_nettype wire

// >>> design/sspp_irq.v
// sticky event status with mask and read-to-clear
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defines.vh"
module sspp_irq (
  input wire clk,
  input wire arst_n,
  input wire [`SSPP_EV_N-1:0] ev,
  input wire [`SSPP_EV_N-1:0] mask,
  input wire rd_clr,
  output wire [`SSPP_EV_N-1:0] status,
  output reg irq
);
  reg [`SSPP_EV_N-1:0] stat_q;
  wire [`SSPP_EV_N-1:0] stat_d;

  genvar i;
  generate
    for (i = 0; i < `SSPP_EV_N; i = i + 1) begin : g_bit
      // set wins over the read clear so no event is lost
      assign stat_d[i] = ev[i] | (stat_q[i] & ~rd_clr);
    end
  endgenerate

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= {`SSPP_EV_N{1'b0}};
      irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq <= |(stat_d & mask);
    end
  end

  assign status = stat_q;
endmodule // sspp_irq
`default_nettype wire

// >>> design/sspp_seq_top.v
// power-on sequencing, soft start/stop, power good and pin polarity with apb registers
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defines.vh"
// Behaviour
// - wait coded delay before soft start
// - soft stop enabled ramps down on faults too
// - soft stop lasts the soft start time
// - coded soft start ramp 360us to 40ms
// - primary power good waits debounce, limits ok
// - coded primary power good debounce time
// - power-on release debounced before power good drops
// - flag option lets every flag reach secondary
// - external fault input polarity bit
// - oring gate output polarity bit
// - power-on request pin polarity bit
module sspp_seq_top #(
  parameter [31:0] CYC_DLY_HALF = `SSPP_DLY_HALF_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_DLY_ONE = `SSPP_DLY_ONE_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_DLY_TWO = `SSPP_DLY_TWO_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_SS_360U = `SSPP_SS_360_US * (`SSPP_CLK_HZ / 1000000),
  parameter [31:0] CYC_SS_10M = `SSPP_SS_10_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_SS_20M = `SSPP_SS_20_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_SS_40M = `SSPP_SS_40_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_DEB_320M = `SSPP_DEB_320_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_DEB_200M = `SSPP_DEB_200_MS * (`SSPP_CLK_HZ / 1000),
  parameter [31:0] CYC_DEB_600M = `SSPP_DEB_600_MS * (`SSPP_CLK_HZ / 1000)
) (
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SSPP_AW-1:0] paddr,
  input wire [`SSPP_DW-1:0] pwdata,
  output reg [`SSPP_DW-1:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire power_on_request_pin,
  input wire external_fault_input,
  input wire [`SSPP_LIM_N-1:0] limit_fault,
  input wire [`SSPP_LIM_N:0] flag_ignore,
  output reg switching_en,
  output reg softstart_active,
  output reg softstop_active,
  output reg oring_gate_out,
  output reg power_good_primary_out,
  output reg power_good_secondary_out,
  output wire irq
);
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_RAMP_UP = 3'h2;
  localparam [2:0] ST_ON = 3'h3;
  localparam [2:0] ST_RAMP_DN = 3'h4;

  function [`SSPP_AW-1:0] idx_addr;
    input [7:0] idx;
    begin
      idx_addr = {idx[5:0], 2'b00};
    end
  endfunction

  function addr_known;
    input [`SSPP_AW-1:0] a;
    begin
      addr_known = (a == idx_addr(`SSPP_IDX_PWRSS)) || (a == idx_addr(`SSPP_IDX_POL)) ||
                   (a == `SSPP_ADDR_STAT) || (a == `SSPP_ADDR_MASK) || (a == `SSPP_ADDR_MON);
    end
  endfunction

  function [`SSPP_CW-1:0] delay_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0: delay_cycles = {`SSPP_CW{1'b0}};
        2'h1: delay_cycles = CYC_DLY_HALF[`SSPP_CW-1:0];
        2'h2: delay_cycles = CYC_DLY_ONE[`SSPP_CW-1:0];
        default: delay_cycles = CYC_DLY_TWO[`SSPP_CW-1:0];
      endcase
    end
  endfunction

  function [`SSPP_CW-1:0] ramp_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0: ramp_cycles = CYC_SS_360U[`SSPP_CW-1:0];
        2'h1: ramp_cycles = CYC_SS_10M[`SSPP_CW-1:0];
        2'h2: ramp_cycles = CYC_SS_20M[`SSPP_CW-1:0];
        default: ramp_cycles = CYC_SS_40M[`SSPP_CW-1:0];
      endcase
    end
  endfunction

  // only the upper two code bits are decoded; each listed value repeats over four codes
  function [`SSPP_CW-1:0] debounce_cycles;
    input [3:0] code;
    begin
      case (code[3:2])
        2'h0: debounce_cycles = CYC_DEB_320M[`SSPP_CW-1:0];
        2'h1: debounce_cycles = CYC_DEB_200M[`SSPP_CW-1:0];
        2'h2: debounce_cycles = CYC_DEB_600M[`SSPP_CW-1:0];
        default: debounce_cycles = {`SSPP_CW{1'b0}};
      endcase
    end
  endfunction

  // registers
  reg [7:0] pwrss_q;
  reg [7:0] pol_q;
  reg [`SSPP_EV_N-1:0] mask_q;
  wire [`SSPP_EV_N-1:0] status;

  // apb decode: zero wait states, error on unknown address
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire stat_rd_clr = apb_access & ~pwrite & (paddr == `SSPP_ADDR_STAT);

  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_known(paddr);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrss_q <= `SSPP_PWRSS_RST;
      pol_q <= `SSPP_POL_RST;
      mask_q <= `SSPP_MASK_RST;
    end else if (apb_wr) begin
      if (paddr == idx_addr(`SSPP_IDX_PWRSS)) begin
        pwrss_q <= pwdata[7:0];
      end
      if (paddr == idx_addr(`SSPP_IDX_POL)) begin
        pol_q <= pwdata[7:0];
      end
      if (paddr == `SSPP_ADDR_MASK) begin
        mask_q <= pwdata[`SSPP_EV_N-1:0];
      end
    end
  end

  // input polarity first, ahead of any timing or fault use
  wire pin_on = power_on_request_pin ^ pol_q[`SSPP_PONPOL_BIT];
  wire ext_flag = external_fault_input ^ pol_q[`SSPP_FLPOL_BIT];

  reg pon;
  always @* begin
    case (pwrss_q[`SSPP_SRC_HI:`SSPP_SRC_LO])
      `SSPP_SRC_ALWAYS: pon = 1'b1;
      `SSPP_SRC_PIN: pon = pin_on;
      `SSPP_SRC_SW: pon = pwrss_q[`SSPP_SWON_BIT];
      default: pon = pin_on & pwrss_q[`SSPP_SWON_BIT];
    endcase
  end

  // fault flags: the limit checks plus the external input
  wire [`SSPP_LIM_N:0] flags = {limit_fault, ext_flag};
  wire limits_ok = ~|limit_fault;
  wire shut_fault = |(flags & ~flag_ignore);
  // with the option set, ignored flags still count for the secondary good
  wire pg2_bad = pol_q[`SSPP_PG2ALL_BIT] ? (|flags) : shut_fault;
  wire soft_stop_en = pwrss_q[`SSPP_SSTOP_BIT];
  wire [`SSPP_CW-1:0] ramp_val = ramp_cycles(pwrss_q[`SSPP_SS_HI:`SSPP_SS_LO]);

  // sequencer
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg seq_load;
  reg [`SSPP_CW-1:0] seq_val;
  reg ev_fault_off;
  reg ev_ss_done;
  reg ev_stop_done;
  wire seq_expired;

  sspp_timer u_seq_tmr (
    .clk(clk),
    .arst_n(arst_n),
    .load(seq_load),
    .load_val(seq_val),
    .expired(seq_expired)
  );

  always @* begin
    state_d = state_q;
    seq_load = 1'b0;
    seq_val = ramp_val;
    ev_fault_off = 1'b0;
    ev_ss_done = 1'b0;
    ev_stop_done = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (pon && !shut_fault) begin
          state_d = ST_DELAY;
          seq_load = 1'b1;
          seq_val = delay_cycles(pwrss_q[`SSPP_DLY_HI:`SSPP_DLY_LO]);
        end
      end
      ST_DELAY: begin
        if (!pon || shut_fault) begin
          state_d = ST_OFF;
        end else if (seq_expired) begin
          state_d = ST_RAMP_UP;
          seq_load = 1'b1;
        end
      end
      ST_RAMP_UP, ST_ON: begin
        if (shut_fault || !pon) begin
          ev_fault_off = shut_fault;
          if (soft_stop_en) begin
            // stop ramp reuses the start ramp length
            state_d = ST_RAMP_DN;
            seq_load = 1'b1;
          end else begin
            state_d = ST_OFF;
          end
        end else if (state_q == ST_RAMP_UP && seq_expired) begin
          state_d = ST_ON;
          ev_ss_done = 1'b1;
        end
      end
      ST_RAMP_DN: begin
        // a started stop ramp always runs to its end
        if (seq_expired) begin
          state_d = ST_OFF;
          ev_stop_done = 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_OFF;
      switching_en <= 1'b0;
      softstart_active <= 1'b0;
      softstop_active <= 1'b0;
      oring_gate_out <= 1'b0;
    end else begin
      state_q <= state_d;
      switching_en <= (state_d == ST_RAMP_UP) || (state_d == ST_ON) || (state_d == ST_RAMP_DN);
      softstart_active <= (state_d == ST_RAMP_UP);
      softstop_active <= (state_d == ST_RAMP_DN);
      // gate on once the output has reached nominal
      oring_gate_out <= (state_d == ST_ON) ^ pol_q[`SSPP_GATEPOL_BIT];
    end
  end

  // primary power good with its own debounce timer
  reg pg_arm_q;
  reg pg_arm_d;
  reg pg1_d;
  reg pg_load;
  wire pg_expired;
  wire [`SSPP_CW-1:0] deb_val = debounce_cycles(pol_q[`SSPP_DEB_HI:`SSPP_DEB_LO]);

  sspp_timer u_pg_tmr (
    .clk(clk),
    .arst_n(arst_n),
    .load(pg_load),
    .load_val(deb_val),
    .expired(pg_expired)
  );

  always @* begin
    pg1_d = power_good_primary_out;
    pg_arm_d = pg_arm_q;
    pg_load = 1'b0;
    if (!power_good_primary_out) begin
      if (!(state_q == ST_ON && limits_ok && pon)) begin
        pg_arm_d = 1'b0;
      end else if (!pg_arm_q) begin
        pg_arm_d = 1'b1;
        pg_load = 1'b1;
      end else if (pg_expired) begin
        pg1_d = 1'b1;
        pg_arm_d = 1'b0;
      end
    end else begin
      // a real fault drops good at once, only a power-off request is debounced
      if (!limits_ok || shut_fault) begin
        pg1_d = 1'b0;
        pg_arm_d = 1'b0;
      end else if (pon) begin
        pg_arm_d = 1'b0;
      end else if (!pg_arm_q) begin
        pg_arm_d = 1'b1;
        pg_load = 1'b1;
      end else if (pg_expired) begin
        pg1_d = 1'b0;
        pg_arm_d = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_good_primary_out <= 1'b0;
      power_good_secondary_out <= 1'b0;
      pg_arm_q <= 1'b0;
    end else begin
      power_good_primary_out <= pg1_d;
      power_good_secondary_out <= ~pg2_bad;
      pg_arm_q <= pg_arm_d;
    end
  end

  // events into the interrupt block
  wire [`SSPP_EV_N-1:0] ev;
  assign ev[`SSPP_EV_PG1_RISE] = pg1_d & ~power_good_primary_out;
  assign ev[`SSPP_EV_PG1_FALL] = ~pg1_d & power_good_primary_out;
  assign ev[`SSPP_EV_FAULT_OFF] = ev_fault_off;
  assign ev[`SSPP_EV_SS_DONE] = ev_ss_done;
  assign ev[`SSPP_EV_STOP_DONE] = ev_stop_done;
  assign ev[`SSPP_EV_PG2_FALL] = pg2_bad & power_good_secondary_out;

  sspp_irq u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .ev(ev),
    .mask(mask_q),
    .rd_clr(stat_rd_clr),
    .status(status),
    .irq(irq)
  );

  // read data captured in the setup cycle, stable through the access
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= {`SSPP_DW{1'b0}};
    end else if (apb_setup && !pwrite) begin
      if (paddr == idx_addr(`SSPP_IDX_PWRSS)) begin
        prdata <= {24'h000000, pwrss_q};
      end else if (paddr == idx_addr(`SSPP_IDX_POL)) begin
        prdata <= {24'h000000, pol_q};
      end else if (paddr == `SSPP_ADDR_STAT) begin
        // include this cycle's events: the access edge clears them, so they must be reported
        prdata <= {26'h0000000, status | ev};
      end else if (paddr == `SSPP_ADDR_MASK) begin
        prdata <= {26'h0000000, mask_q};
      end else if (paddr == `SSPP_ADDR_MON) begin
        prdata <= {24'h000000, power_good_secondary_out, power_good_primary_out, pon, switching_en,
                   pg_arm_q, state_q};
      end else begin
        prdata <= {`SSPP_DW{1'b0}};
      end
    end
  end
endmodule // sspp_seq_top
`default_nettype wire

// >>> bench/sspp_seq_sva.sv
// port-level assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defines.vh"
module sspp_seq_sva #(
  parameter [31:0] CYC_SS_360U = 20,
  parameter [31:0] CYC_SS_10M = 30,
  parameter [31:0] CYC_SS_20M = 50,
  parameter [31:0] CYC_SS_40M = 70,
  parameter [31:0] CYC_DEB_320M = 90,
  parameter [31:0] CYC_DEB_200M = 100,
  parameter [31:0] CYC_DEB_600M = 120
) (
  input wire clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SSPP_AW-1:0] paddr,
  input wire [`SSPP_DW-1:0] pwdata,
  input wire external_fault_input,
  input wire [`SSPP_LIM_N-1:0] limit_fault,
  input wire [`SSPP_LIM_N:0] flag_ignore,
  input wire switching_en,
  input wire softstart_active,
  input wire softstop_active,
  input wire oring_gate_out,
  input wire power_good_primary_out,
  input wire power_good_secondary_out
);
  // register copies snooped from apb writes, so polarity can be judged
  reg [7:0] pwr_q;
  reg [7:0] pol_q;
  reg [15:0] ss_q;
  reg [15:0] sp_q;
  reg [15:0] on_q;
  wire wr = psel & penable & pwrite;
  wire on_st = switching_en & ~softstart_active & ~softstop_active;
  wire fl = external_fault_input ^ pol_q[`SSPP_FLPOL_BIT];
  wire cnt_f = |(limit_fault & ~flag_ignore[7:1]) | (fl & ~flag_ignore[0]);
  wire all_f = |limit_fault | fl;
  wire [2:0] g_w = {on_st, switching_en, pol_q[`SSPP_GATEPOL_BIT]};
  wire [1:0] sc = pwr_q[1:0];
  wire [1:0] dc = pol_q[7:6];
  wire [31:0] ramp = sc == 2'h0 ? CYC_SS_360U : sc == 2'h1 ? CYC_SS_10M : sc == 2'h2 ? CYC_SS_20M : CYC_SS_40M;
  wire [31:0] deb = dc == 2'h0 ? CYC_DEB_320M : dc == 2'h1 ? CYC_DEB_200M : dc == 2'h2 ? CYC_DEB_600M : 32'h0;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_q <= 8'h00;
      pol_q <= 8'h00;
      ss_q <= 16'h0;
      sp_q <= 16'h0;
      on_q <= 16'h0;
    end else begin
      if (wr && paddr == (`SSPP_IDX_PWRSS << 2)) pwr_q <= pwdata[7:0];
      if (wr && paddr == (`SSPP_IDX_POL << 2)) pol_q <= pwdata[7:0];
      ss_q <= softstart_active ? ss_q + 16'h1 : 16'h0;
      sp_q <= softstop_active ? sp_q + 16'h1 : 16'h0;
      on_q <= (on_st && limit_fault == 0) ? on_q + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_on_fault;
    on_st && cnt_f;
  endsequence
  property p_ss_en;
    softstart_active |-> switching_en && !softstop_active;
  endproperty
  a_ss_en: assert property (p_ss_en) else $error("ramp up without switching");
  property p_ss_len;
    $fell(softstart_active) && on_st |-> ss_q == ramp + 1;
  endproperty
  a_ss_len: assert property (p_ss_len) else $error("ramp up length wrong");
  property p_sp_len;
    $fell(softstop_active) |-> sp_q == ramp + 1;
  endproperty
  a_sp_len: assert property (p_sp_len) else $error("ramp down length wrong");
  property p_sstop;
    s_on_fault and pwr_q[`SSPP_SSTOP_BIT] |=> softstop_active;
  endproperty
  a_sstop: assert property (p_sstop) else $error("fault did not ramp down");
  property p_hard;
    s_on_fault and !pwr_q[`SSPP_SSTOP_BIT] |=> !switching_en;
  endproperty
  a_hard: assert property (p_hard) else $error("fault did not stop at once");
  property p_lim_pg1;
    limit_fault != 0 |=> !power_good_primary_out;
  endproperty
  a_lim_pg1: assert property (p_lim_pg1) else $error("good while out of limits");
  property p_pg1_deb;
    $rose(power_good_primary_out) |-> on_q > deb;
  endproperty
  a_pg1_deb: assert property (p_pg1_deb) else $error("good before debounce");
  property p_pg2_sel;
    $past(arst_n) && !$past(pol_q[`SSPP_PG2ALL_BIT]) |-> power_good_secondary_out == !$past(cnt_f);
  endproperty
  a_pg2_sel: assert property (p_pg2_sel) else $error("secondary good wrong");
  property p_pg2_all;
    $past(arst_n) && $past(pol_q[`SSPP_PG2ALL_BIT]) |-> power_good_secondary_out == !$past(all_f);
  endproperty
  a_pg2_all: assert property (p_pg2_all) else $error("secondary good misses a flag");
  property p_gate;
    $past(arst_n, 2) && g_w == $past(g_w) && g_w == $past(g_w, 2) && (on_st || !switching_en)
      |-> oring_gate_out == (on_st ^ pol_q[`SSPP_GATEPOL_BIT]);
  endproperty
  a_gate: assert property (p_gate) else $error("gate level wrong");
endmodule // sspp_seq_sva
bind sspp_seq_top sspp_seq_sva #(.CYC_SS_360U(CYC_SS_360U), .CYC_SS_10M(CYC_SS_10M), .CYC_SS_20M(CYC_SS_20M),
  .CYC_SS_40M(CYC_SS_40M), .CYC_DEB_320M(CYC_DEB_320M), .CYC_DEB_200M(CYC_DEB_200M), .CYC_DEB_600M(CYC_DEB_600M))
  u_sva (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .external_fault_input(external_fault_input), .limit_fault(limit_fault),
  .flag_ignore(flag_ignore), .switching_en(switching_en), .softstart_active(softstart_active),
  .softstop_active(softstop_active), .oring_gate_out(oring_gate_out),
  .power_good_primary_out(power_good_primary_out), .power_good_secondary_out(power_good_secondary_out));
`default_nettype wire

// >>> bench/sspp_host_model.sv
// host side: power-on request pin and external flag at chosen polarity
`timescale 1ns/1ps
`default_nettype none
module sspp_host_model (
  input wire logic want_on,
  input wire logic want_flag,
  input wire logic pin_pol,
  input wire logic flag_pol,
  output logic power_on_request_pin,
  output logic external_fault_input
);
  // combinational so a request lands the cycle the bench asks for it
  assign power_on_request_pin = want_on ^ pin_pol;
  assign external_fault_input = want_flag ^ flag_pol;
endmodule // sspp_host_model
`default_nettype wire

// >>> bench/sspp_seq_tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sspp_defines.vh"
module sspp_seq_tb;
  localparam [31:0] DH = 40, D1 = 60, D2 = 80, S0 = 20, S1 = 30, S2 = 50, S3 = 70, B0 = 90, B1 = 100, B2 = 120;
  localparam [7:0] A_PWR = `SSPP_IDX_PWRSS << 2;
  localparam [7:0] A_POL = `SSPP_IDX_POL << 2;
  typedef struct {logic [7:0] pwr; logic [7:0] pol; int dly; int ramp; int deb;} sspp_row_t;
  sspp_row_t rows [4] = '{'{8'h44, 8'h00, 0, S0, B0}, '{8'h4D, 8'h43, DH, S1, B1},
    '{8'h56, 8'h81, D1, S2, B2}, '{8'h5F, 8'hC2, D2, S3, 0}};
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, want_on = 0, want_fl = 0, e;
  logic [7:0] paddr = 8'h00, pol_now = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [6:0] limit_fault = 7'h00;
  logic [7:0] flag_ignore = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, pin, fin, sw, ss, sp, gate, pg1, pg2, irq;
  int num_errors = 0, tests_run = 0, n, k1, k2;
  sspp_seq_top #(.CYC_DLY_HALF(DH), .CYC_DLY_ONE(D1), .CYC_DLY_TWO(D2), .CYC_SS_360U(S0), .CYC_SS_10M(S1),
    .CYC_SS_20M(S2), .CYC_SS_40M(S3), .CYC_DEB_320M(B0), .CYC_DEB_200M(B1), .CYC_DEB_600M(B2)) uut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_on_request_pin(pin),
    .external_fault_input(fin), .limit_fault(limit_fault), .flag_ignore(flag_ignore), .switching_en(sw),
    .softstart_active(ss), .softstop_active(sp), .oring_gate_out(gate), .power_good_primary_out(pg1),
    .power_good_secondary_out(pg2), .irq(irq));
  sspp_host_model host (.want_on(want_on), .want_flag(want_fl), .pin_pol(pol_now[0]), .flag_pol(pol_now[2]),
    .power_on_request_pin(pin), .external_fault_input(fin));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function logic sig(int s);
    case (s)
      0: return sw;
      1: return ss;
      2: return sp;
      default: return pg1;
    endcase
  endfunction
  // bounded so a dead output cannot hang the run
  task till(input int s, input logic lv);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sig(s) !== lv && n < 3000);
  endtask
  task summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(25 * 30000);
    num_errors++;
    summarize;
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1;
    apb(0, A_PWR, 0);
    check("pwr_rst", rd, {24'h0, `SSPP_PWRSS_RST});
    apb(0, A_POL, 0);
    check("pol_rst", rd, {24'h0, `SSPP_POL_RST});
    apb(0, `SSPP_ADDR_MASK, 0);
    check("mask_rst", rd, {26'h0, `SSPP_MASK_RST});
    apb(0, 8'hF0, 0);
    check("unmapped_err", e, 1);
    check("unmapped_data", rd, 0);
    check("pready", pready, 1);
    apb(1, A_PWR, 32'h40);
    till(3, 0);
    foreach (rows[i]) begin
      apb(1, A_POL, rows[i].pol);
      pol_now <= rows[i].pol;
      apb(1, A_PWR, rows[i].pwr);
      @(posedge clk);
      want_on <= 1;
      till(0, 1);
      check("start_delay", n, rows[i].dly + 2);
      till(1, 0);
      check("ramp_up", n, rows[i].ramp + 1);
      till(3, 1);
      check("pg1_on", n >= rows[i].deb + 1 && n <= rows[i].deb + 3, 1);
      check("gate_on", gate, !rows[i].pol[1]);
      @(posedge clk);
      want_on <= 0;
      n = 0;
      k1 = 0;
      k2 = 0;
      while ((k1 == 0 || k2 == 0) && n < 3000) begin
        @(posedge clk);
        #1;
        n++;
        if (k1 == 0 && sp === 1'b0 && sw === 1'b0) k1 = n;
        if (k2 == 0 && pg1 === 1'b0) k2 = n;
      end
      check("ramp_down", k1, rows[i].ramp + 2);
      check("pg1_off", k2 >= rows[i].deb && k2 <= rows[i].deb + 3, 1);
      check("gate_off", gate, rows[i].pol[1]);
    end
    // fault with soft stop: ramp down, mask passes only the shutdown event
    apb(1, A_POL, 32'hC0);
    pol_now <= 8'hC0;
    apb(1, A_PWR, 32'h44);
    apb(1, `SSPP_ADDR_MASK, 32'h04);
    apb(0, `SSPP_ADDR_STAT, 0);
    @(posedge clk);
    want_on <= 1;
    till(0, 1);
    till(1, 0);
    @(posedge clk);
    limit_fault <= 7'h01;
    @(posedge clk);
    #1;
    check("fault_sstop", sp, 1);
    check("fault_pg1", pg1, 0);
    till(2, 0);
    check("sstop_len", n, S0 + 1);
    check("irq_set", irq, 1);
    apb(0, `SSPP_ADDR_STAT, 0);
    check("stat_fault", rd[`SSPP_EV_FAULT_OFF], 1);
    repeat (2) @(posedge clk);
    #1;
    check("irq_clr", irq, 0);
    @(posedge clk);
    limit_fault <= 7'h00;
    want_on <= 0;
    // inverted flag input, hard stop, then secondary good options
    apb(1, A_POL, 32'hC4);
    pol_now <= 8'hC4;
    apb(1, A_PWR, 32'h40);
    @(posedge clk);
    want_on <= 1;
    till(0, 1);
    till(1, 0);
    check("pg2_idle", pg2, 1);
    @(posedge clk);
    want_fl <= 1;
    till(0, 0);
    check("hard_stop", n <= 2, 1);
    check("pg2_flag", pg2, 0);
    @(posedge clk);
    flag_ignore <= 8'h01;
    repeat (2) @(posedge clk);
    #1;
    check("pg2_ignored", pg2, 1);
    apb(1, A_POL, 32'hCC);
    repeat (2) @(posedge clk);
    #1;
    check("pg2_all", pg2, 0);
    // power-on source codes: pin and bit, then bit alone
    apb(1, A_PWR, 32'hC0);
    till(0, 0);
    check("src_both_off", n, 1);
    apb(1, A_PWR, 32'hE0);
    till(0, 1);
    check("src_both_on", n, 2);
    apb(1, A_PWR, 32'h80);
    till(0, 0);
    check("src_sw_off", n, 1);
    summarize;
  end
endmodule // sspp_seq_tb
`default_nettype wire
